//--- hw/pmrc_consts.svh
// constants of the power-mode and reset controller
`ifndef PMRC_CONSTS_SVH
`define PMRC_CONSTS_SVH

// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define PMRC_OFS_CTRL       8'h00
`define PMRC_OFS_STATUS     8'h04
`define PMRC_OFS_WAKE_EN    8'h08
`define PMRC_OFS_IRQ_EN     8'h0C
`define PMRC_OFS_CAUSE      8'h10
`define PMRC_OFS_INT_STAT   8'h14
`define PMRC_OFS_INT_MASK   8'h18
`define PMRC_OFS_UNIT_EN    8'h1C
`define PMRC_OFS_RTC_TRIM   8'h20

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define PMRC_CTRL_IDLE      0
`define PMRC_CTRL_SLEEP     1
`define PMRC_CTRL_OSC_KEEP  2
`define PMRC_CTRL_SWRST     3
`define PMRC_CAUSE_HARD     4'h1
`define PMRC_CAUSE_SOFT     4'h2
`define PMRC_CAUSE_WDOG     4'h4
`define PMRC_CAUSE_SLEEP    4'h8
`define PMRC_INT_IDLE_EXIT  0
`define PMRC_INT_WAKE_DONE  1

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define PMRC_RST_UNIT_EN    8'hFF
`define PMRC_RST_MASK8      8'h00
`define PMRC_RST_TRIM       8'h00

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define PMRC_CLK_HZ         32'h05F5_E100
`define PMRC_RTC_HZ         32'h0000_8000
`define PMRC_MS_DIV         32'h0000_03E8
`define PMRC_WAKE_FAST_MS   32'h0000_000A
`define PMRC_WAKE_SLOW_MS   32'h0000_00A0
`define PMRC_WAKE_W         25
`define PMRC_RST_PULSE      5'h10

`endif

//--- hw/pmrc_pkg.sv
// types of the power-mode and reset controller
package pmrc_pkg;

	typedef enum logic [4:0] {
		PMRC_NORMAL   = 5'h01,
		PMRC_IDLE     = 5'h02,
		PMRC_SR_ENTER = 5'h04,
		PMRC_SLEEP    = 5'h08,
		PMRC_WAKE     = 5'h10
	} pmrc_state_type;

	typedef struct packed {
		pmrc_state_type st;
		logic           osc_keep;
		logic [7:0]     wake_en;
		logic [7:0]     irq_en;
		logic [7:0]     unit_en;
		logic [7:0]     trim;
		logic [3:0]     cause;
		logic [1:0]     int_stat;
		logic [1:0]     int_mask;
		logic [4:0]     rst_cnt;
		logic [31:0]    rdata;
		logic           wake_start;
		logic           hard_s1;
		logic           hard_s2;
		logic           ack_s1;
		logic           ack_s2;
	} pmrc_ctl_type;

	typedef struct packed {
		logic [24:0] cnt;
		logic        busy;
		logic        done;
	} pmrc_timer_type;

	typedef struct packed {
		logic [26:0] acc;
		logic        tick;
	} pmrc_rtc_type;

endpackage

//--- hw/pmrc_rtc_tick.sv
// real-time clock tick: trimmed 32.768 kHz enable derived from the system clock
`timescale 1ns/1ps
`include "pmrc_consts.svh"
module pmrc_rtc_tick (
	input  wire logic       CLK_IN,
	input  wire logic       RST_IN,
	input  wire logic [7:0] trim_in,
	output logic            tick_out
);
	pmrc_pkg::pmrc_rtc_type r;
	pmrc_pkg::pmrc_rtc_type next_r;
	logic [26:0] sum;

	// phase accumulator: trim speeds the tick up by whole hertz
	always_comb begin
		next_r = r;
		sum = r.acc + 27'(`PMRC_RTC_HZ) + {19'h00000, trim_in};
		next_r.tick = 1'b0;
		if (sum >= 27'(`PMRC_CLK_HZ)) begin
			next_r.acc = sum - 27'(`PMRC_CLK_HZ);
			next_r.tick = 1'b1;
		end else begin
			next_r.acc = sum;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign tick_out = r.tick;

	chk_rtc_spacing: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		r.tick |=> !r.tick [*8])
		else $error("rtc ticks too close together");
endmodule

//--- hw/pmrc_top.sv
// power-mode sequencing, clock gating and reset control
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "pmrc_consts.svh"
module pmrc_top #(
	parameter int unsigned WAKE_FAST_CYCLES = `PMRC_WAKE_FAST_MS * (`PMRC_CLK_HZ / `PMRC_MS_DIV),
	parameter int unsigned WAKE_SLOW_CYCLES = `PMRC_WAKE_SLOW_MS * (`PMRC_CLK_HZ / `PMRC_MS_DIV)
) (
	input  wire logic        CLK_IN,
	input  wire logic        RST_IN,
	input  wire logic        HARD_RST_N_IN,
	input  wire logic [7:0]  ADDR_IN,
	input  wire logic [31:0] WDATA_IN,
	input  wire logic        WR_IN,
	input  wire logic        RD_IN,
	output logic      [31:0] RDATA_OUT,
	input  wire logic [7:0]  IRQ_SRC_IN,
	input  wire logic        WDOG_MATCH_IN,
	input  wire logic [7:0]  UNIT_BUSY_IN,
	input  wire logic        DRAM_SR_ACK_IN,
	output logic             DRAM_SR_REQ_OUT,
	output logic             CPU_CLK_EN_OUT,
	output logic      [7:0]  PERIPH_CLK_EN_OUT,
	output logic             FAST_OSC_EN_OUT,
	output logic             RTC_TICK_OUT,
	output logic      [2:0]  MODE_OUT,
	output logic             SYS_RST_OUT,
	output logic             IRQ_OUT
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	pmrc_pkg::pmrc_ctl_type r;
	pmrc_pkg::pmrc_ctl_type next_r;

	logic       wake_done;
	logic       wr_ctrl;
	logic       sw_reset;
	logic       hard_req;
	logic       rst_trig;
	logic [3:0] rst_cause;
	logic [7:0] irq_pending;
	logic [7:0] wake_pending;
	logic [1:0] int_event;
	logic [1:0] int_clear;
	logic [`PMRC_WAKE_W-1:0] wake_load;

	assign wr_ctrl      = WR_IN && (ADDR_IN == `PMRC_OFS_CTRL);
	assign sw_reset     = wr_ctrl && WDATA_IN[`PMRC_CTRL_SWRST];
	assign hard_req     = !r.hard_s2;
	assign irq_pending  = IRQ_SRC_IN & r.irq_en;
	assign wake_pending = IRQ_SRC_IN & r.wake_en;
	assign wake_load    = r.osc_keep ? `PMRC_WAKE_W'(WAKE_FAST_CYCLES) :
		`PMRC_WAKE_W'(WAKE_SLOW_CYCLES);

	// ---------------------------------------------------------------
	// reset merge
	// ---------------------------------------------------------------
	// priority hard, watchdog, software, wake: a held pin must never be masked
	always_comb begin
		rst_cause = 4'h0;
		if (hard_req) begin
			rst_cause = `PMRC_CAUSE_HARD;
		end else if (WDOG_MATCH_IN) begin
			rst_cause = `PMRC_CAUSE_WDOG;
		end else if (sw_reset) begin
			rst_cause = `PMRC_CAUSE_SOFT;
		end else if (wake_done) begin
			rst_cause = `PMRC_CAUSE_SLEEP;
		end
	end
	assign rst_trig = |rst_cause;

	// ---------------------------------------------------------------
	// sequencer and registers
	// ---------------------------------------------------------------
	always_comb begin
		next_r = r;
		int_event = 2'h0;
		int_clear = 2'h0;
		next_r.wake_start = 1'b0;
		next_r.hard_s1 = HARD_RST_N_IN;
		next_r.hard_s2 = r.hard_s1;
		next_r.ack_s1 = DRAM_SR_ACK_IN;
		next_r.ack_s2 = r.ack_s1;

		case (r.st)
			pmrc_pkg::PMRC_NORMAL: begin
				if (wr_ctrl && WDATA_IN[`PMRC_CTRL_SLEEP]) begin
					next_r.st = pmrc_pkg::PMRC_SR_ENTER;
				end else if (wr_ctrl && WDATA_IN[`PMRC_CTRL_IDLE]) begin
					next_r.st = pmrc_pkg::PMRC_IDLE;
				end
			end
			pmrc_pkg::PMRC_IDLE: begin
				if (|irq_pending) begin
					next_r.st = pmrc_pkg::PMRC_NORMAL;
					int_event[`PMRC_INT_IDLE_EXIT] = 1'b1;
				end
			end
			pmrc_pkg::PMRC_SR_ENTER: begin
				if (r.ack_s2) begin
					next_r.st = pmrc_pkg::PMRC_SLEEP;
				end
			end
			pmrc_pkg::PMRC_SLEEP: begin
				if (|wake_pending) begin
					next_r.st = pmrc_pkg::PMRC_WAKE;
					next_r.wake_start = 1'b1;
				end
			end
			pmrc_pkg::PMRC_WAKE: begin
				if (wake_done) begin
					next_r.st = pmrc_pkg::PMRC_NORMAL;
					int_event[`PMRC_INT_WAKE_DONE] = 1'b1;
				end
			end
			default: begin
				next_r.st = pmrc_pkg::PMRC_NORMAL;
			end
		endcase

		if (WR_IN) begin
			case (ADDR_IN)
				`PMRC_OFS_CTRL:     next_r.osc_keep = WDATA_IN[`PMRC_CTRL_OSC_KEEP];
				`PMRC_OFS_WAKE_EN:  next_r.wake_en = WDATA_IN[7:0];
				`PMRC_OFS_IRQ_EN:   next_r.irq_en = WDATA_IN[7:0];
				`PMRC_OFS_INT_STAT: int_clear = WDATA_IN[1:0];
				`PMRC_OFS_INT_MASK: next_r.int_mask = WDATA_IN[1:0];
				`PMRC_OFS_UNIT_EN:  next_r.unit_en = WDATA_IN[7:0];
				`PMRC_OFS_RTC_TRIM: next_r.trim = WDATA_IN[7:0];
				default: begin
				end
			endcase
		end
		// an event in the clearing cycle survives the clear
		next_r.int_stat = (r.int_stat & ~int_clear) | int_event;

		if (rst_trig) begin
			next_r.cause = rst_cause;
			next_r.rst_cnt = `PMRC_RST_PULSE;
			next_r.st = pmrc_pkg::PMRC_NORMAL;
		end else if (r.rst_cnt != 5'h00) begin
			next_r.rst_cnt = r.rst_cnt - 5'h01;
		end

		next_r.rdata = 32'h0000_0000;
		if (RD_IN) begin
			case (ADDR_IN)
				`PMRC_OFS_CTRL:     next_r.rdata = {29'h0, r.osc_keep, 2'h0};
				`PMRC_OFS_STATUS:   next_r.rdata = {27'h0, r.st};
				`PMRC_OFS_WAKE_EN:  next_r.rdata = {24'h0, r.wake_en};
				`PMRC_OFS_IRQ_EN:   next_r.rdata = {24'h0, r.irq_en};
				`PMRC_OFS_CAUSE:    next_r.rdata = {28'h0, r.cause};
				`PMRC_OFS_INT_STAT: next_r.rdata = {30'h0, r.int_stat};
				`PMRC_OFS_INT_MASK: next_r.rdata = {30'h0, r.int_mask};
				`PMRC_OFS_UNIT_EN:  next_r.rdata = {24'h0, r.unit_en};
				`PMRC_OFS_RTC_TRIM: next_r.rdata = {24'h0, r.trim};
				default:            next_r.rdata = 32'h0000_0000;
			endcase
		end
	end

	// the cause register survives the system reset; RST_IN and the synchronised HARD_RST_N_IN both mark it hard
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			r.st <= pmrc_pkg::PMRC_NORMAL;
			r.osc_keep <= 1'b0;
			r.wake_en <= `PMRC_RST_MASK8;
			r.irq_en <= `PMRC_RST_MASK8;
			r.unit_en <= `PMRC_RST_UNIT_EN;
			r.trim <= `PMRC_RST_TRIM;
			r.cause <= `PMRC_CAUSE_HARD;
			r.int_stat <= 2'h0;
			r.int_mask <= 2'h0;
			r.rst_cnt <= `PMRC_RST_PULSE;
			r.rdata <= 32'h0000_0000;
			r.wake_start <= 1'b0;
			r.hard_s1 <= 1'b1;
			r.hard_s2 <= 1'b1;
			r.ack_s1 <= 1'b0;
			r.ack_s2 <= 1'b0;
		end else begin
			r <= next_r;
		end
	end

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	pmrc_wake_timer u_wake (
		.CLK_IN   (CLK_IN),
		.RST_IN   (RST_IN),
		.start_in (r.wake_start),
		.load_in  (wake_load),
		.done_out (wake_done)
	);

	// the rtc divider never stops, whatever the mode
	pmrc_rtc_tick u_rtc (
		.CLK_IN   (CLK_IN),
		.RST_IN   (RST_IN),
		.trim_in  (r.trim),
		.tick_out (RTC_TICK_OUT)
	);

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	always_comb begin
		CPU_CLK_EN_OUT = 1'b0;
		PERIPH_CLK_EN_OUT = 8'h00;
		DRAM_SR_REQ_OUT = 1'b0;
		FAST_OSC_EN_OUT = 1'b1;
		MODE_OUT = 3'h1;
		case (r.st)
			pmrc_pkg::PMRC_NORMAL, pmrc_pkg::PMRC_SR_ENTER: begin
				CPU_CLK_EN_OUT = 1'b1;
				PERIPH_CLK_EN_OUT = r.unit_en & UNIT_BUSY_IN;
				DRAM_SR_REQ_OUT = (r.st == pmrc_pkg::PMRC_SR_ENTER);
			end
			pmrc_pkg::PMRC_IDLE: begin
				PERIPH_CLK_EN_OUT = r.unit_en & UNIT_BUSY_IN;
				MODE_OUT = 3'h2;
			end
			pmrc_pkg::PMRC_SLEEP: begin
				DRAM_SR_REQ_OUT = 1'b1;
				FAST_OSC_EN_OUT = r.osc_keep;
				MODE_OUT = 3'h4;
			end
			pmrc_pkg::PMRC_WAKE: begin
				DRAM_SR_REQ_OUT = 1'b1;
				MODE_OUT = 3'h4;
			end
			default: begin
				MODE_OUT = 3'h1;
			end
		endcase
	end

	assign SYS_RST_OUT = (r.rst_cnt != 5'h00);
	assign IRQ_OUT     = |(r.int_stat & r.int_mask);
	assign RDATA_OUT   = r.rdata;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (RST_IN);

	sequence sr_handshake;
		r.st == pmrc_pkg::PMRC_SR_ENTER && DRAM_SR_REQ_OUT ##1 r.st == pmrc_pkg::PMRC_SLEEP;
	endsequence

	sequence wake_finish;
		r.st == pmrc_pkg::PMRC_WAKE && wake_done && !hard_req && !WDOG_MATCH_IN && !sw_reset;
	endsequence

	sequence wake_begin;
		r.st == pmrc_pkg::PMRC_SLEEP && |wake_pending && !rst_trig ##1 r.wake_start;
	endsequence

	chk_one_mode: assert property ($onehot(MODE_OUT) && $onehot(r.st))
		else $error("mode is not one of three");

	chk_normal_gating: assert property (r.st == pmrc_pkg::PMRC_NORMAL && !UNIT_BUSY_IN[0]
		|-> !PERIPH_CLK_EN_OUT[0] && CPU_CLK_EN_OUT)
		else $error("idle unit still clocked in normal mode");

	chk_idle_cpu_off: assert property (MODE_OUT == 3'h2 |-> !CPU_CLK_EN_OUT
		&& PERIPH_CLK_EN_OUT == (r.unit_en & UNIT_BUSY_IN))
		else $error("cpu clock running in idle");

	chk_idle_exit: assert property (r.st == pmrc_pkg::PMRC_IDLE && |(IRQ_SRC_IN & r.irq_en)
		|=> MODE_OUT == 3'h1 && r.int_stat[`PMRC_INT_IDLE_EXIT])
		else $error("enabled interrupt did not end idle");

	chk_sleep_entry: assert property (sr_handshake |-> $past(r.ack_s2)
		&& PERIPH_CLK_EN_OUT == 8'h00 && !CPU_CLK_EN_OUT)
		else $error("sleep entered without self-refresh");

	chk_sleep_hold: assert property (r.st == pmrc_pkg::PMRC_SLEEP && !(|(IRQ_SRC_IN & r.wake_en))
		&& !rst_trig |=> r.st == pmrc_pkg::PMRC_SLEEP)
		else $error("sleep left without a wake source");

	chk_wake_reset: assert property (wake_finish |=> SYS_RST_OUT
		&& r.cause == `PMRC_CAUSE_SLEEP && MODE_OUT == 3'h1)
		else $error("wake end did not reset with sleep cause");

	chk_soft_reset: assert property (sw_reset && !hard_req && !WDOG_MATCH_IN
		|=> r.cause == `PMRC_CAUSE_SOFT ##0 SYS_RST_OUT [*8])
		else $error("software reset not taken");

	chk_wdog_cause: assert property (WDOG_MATCH_IN && !hard_req
		|=> r.cause == `PMRC_CAUSE_WDOG && SYS_RST_OUT)
		else $error("watchdog expiry not recorded");

	chk_cause_kept: assert property (!rst_trig |=> $stable(r.cause))
		else $error("reset cause changed without a reset");

	// ---------------------------------------------------------------
	// checks of the sleep and reset paths
	// ---------------------------------------------------------------
	chk_sleep_dark: assert property (
		MODE_OUT == 3'h4 |-> !CPU_CLK_EN_OUT && PERIPH_CLK_EN_OUT == 8'h00)
		else $error("clocks running in sleep");

	chk_sleep_osc: assert property (
		r.st == pmrc_pkg::PMRC_SLEEP |-> FAST_OSC_EN_OUT == r.osc_keep && DRAM_SR_REQ_OUT)
		else $error("oscillator or self-refresh wrong in sleep");

	chk_wake_begin: assert property (
		wake_begin |-> MODE_OUT == 3'h4 && DRAM_SR_REQ_OUT && !CPU_CLK_EN_OUT)
		else $error("wake wait left the sleep outputs");

	chk_wake_flag: assert property (
		wake_finish |=> r.int_stat[`PMRC_INT_WAKE_DONE])
		else $error("wake done not flagged");

	chk_rst_pulse: assert property (
		rst_trig |=> r.rst_cnt == `PMRC_RST_PULSE && SYS_RST_OUT)
		else $error("reset pulse not reloaded");

	chk_hard_cause: assert property (
		hard_req |=> r.cause == `PMRC_CAUSE_HARD && SYS_RST_OUT)
		else $error("hard reset not recorded");

	chk_cause_read: assert property (
		RD_IN && ADDR_IN == `PMRC_OFS_CAUSE |=> RDATA_OUT == {28'h0, $past(r.cause)})
		else $error("reset cause not readable");
endmodule

//--- hw/pmrc_wake_timer.sv
// wake latency counter: one done pulse a load count after start
`timescale 1ns/1ps
`include "pmrc_consts.svh"
module pmrc_wake_timer (
	input  wire logic                    CLK_IN,
	input  wire logic                    RST_IN,
	input  wire logic                    start_in,
	input  wire logic [`PMRC_WAKE_W-1:0] load_in,
	output logic                         done_out
);
	pmrc_pkg::pmrc_timer_type r;
	pmrc_pkg::pmrc_timer_type next_r;

	always_comb begin
		next_r = r;
		next_r.done = 1'b0;
		if (start_in) begin
			next_r.cnt = load_in;
			next_r.busy = 1'b1;
		end else if (r.busy) begin
			if (r.cnt <= 25'h0000001) begin
				next_r.busy = 1'b0;
				next_r.done = 1'b1;
			end else begin
				next_r.cnt = r.cnt - 25'h0000001;
			end
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign done_out = r.done;

	chk_done_after_count: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		r.done |-> $past(r.busy) && $past(r.cnt) <= 25'h0000001)
		else $error("wake done without finished count");
endmodule

//--- testbench/pmrc_dram_model.sv
// behavioural dram that enters self-refresh on request after a short or long delay
`timescale 1ns/1ps
module pmrc_dram_model (
	input  wire logic CLK_IN,
	input  wire logic slow_in,
	input  wire logic sr_req_in,
	output logic      sr_ack_out
);
	int unsigned wait_cnt = 0;
	initial sr_ack_out = 1'b0;
	always @(posedge CLK_IN) begin
		if (!sr_req_in) begin
			// ack drops with the request so a stale ack never opens the next entry
			wait_cnt <= 0;
			sr_ack_out <= 1'b0;
		end else if (wait_cnt < (slow_in ? 40 : 3)) begin
			wait_cnt <= wait_cnt + 1;
		end else begin
			sr_ack_out <= 1'b1;
		end
	end
endmodule

//--- testbench/pmrc_top_tb_top.sv
// self-checking bench of the power-mode and reset controller
`timescale 1ns/1ps
`include "pmrc_consts.svh"
module pmrc_top_tb_top;
	localparam int FAST = 20;
	localparam int SLOW = 50;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        hard_n = 1'b1;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [7:0]  irq_src = 8'h00;
	logic        wdog = 1'b0;
	logic [7:0]  busy = 8'h00;
	logic        slow_ack = 1'b0;
	logic [31:0] rdata;
	logic        sr_ack, sr_req, cpu_en, osc_en, tick, sys_rst, irq;
	logic [7:0]  periph_en;
	logic [2:0]  mode;
	int          n_mismatch = 0;
	int          checks_done = 0;
	int          cnt;
	int          ticks;

	always #5 clk = ~clk;

	pmrc_top #(.WAKE_FAST_CYCLES(FAST), .WAKE_SLOW_CYCLES(SLOW)) dut (
		.CLK_IN(clk), .RST_IN(rst), .HARD_RST_N_IN(hard_n), .ADDR_IN(addr),
		.WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
		.IRQ_SRC_IN(irq_src), .WDOG_MATCH_IN(wdog), .UNIT_BUSY_IN(busy),
		.DRAM_SR_ACK_IN(sr_ack), .DRAM_SR_REQ_OUT(sr_req), .CPU_CLK_EN_OUT(cpu_en),
		.PERIPH_CLK_EN_OUT(periph_en), .FAST_OSC_EN_OUT(osc_en), .RTC_TICK_OUT(tick),
		.MODE_OUT(mode), .SYS_RST_OUT(sys_rst), .IRQ_OUT(irq)
	);

	pmrc_dram_model dram (.CLK_IN(clk), .slow_in(slow_ack), .sr_req_in(sr_req),
		.sr_ack_out(sr_ack));

	// ---------------------------------------------------------------
	// bus and compare tasks
	// ---------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(what, rdata, exp);
	endtask

	task automatic conclude();
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// ---------------------------------------------------------------
	// sleep entry and timed wake-up
	// ---------------------------------------------------------------
	task automatic sleep_wake(input logic keep, input int n);
		@(posedge clk);
		slow_ack <= ~keep;
		wr_reg(`PMRC_OFS_CTRL, {29'h0, keep, 2'b10});
		cyc(1);
		chk("sr_req", {31'h0, sr_req}, 32'h1);
		chk("early_sleep", {31'h0, mode == 3'b100}, 32'h0);
		cnt = 0;
		while (mode !== 3'b100 && cnt < 200) begin
			cyc(1);
			cnt++;
		end
		chk("sleep_mode", {29'h0, mode}, 32'h4);
		chk("sleep_clks", {23'h0, cpu_en, periph_en}, 32'h0);
		chk("osc_en", {31'h0, osc_en}, {31'h0, keep});
		rd_chk("status_sleep", `PMRC_OFS_STATUS, 32'h8);
		rd_chk("ctrl_keep", `PMRC_OFS_CTRL, {29'h0, keep, 2'h0});
		@(posedge clk);
		irq_src <= 8'h01;
		cyc(5);
		chk("no_wake", {29'h0, mode}, 32'h4);
		@(posedge clk);
		irq_src <= 8'h05;
		cnt = 0;
		// the count runs from the edge that drives the wake source
		while (mode !== 3'b001 && cnt < 1000) begin
			cyc(1);
			cnt++;
		end
		chk("wake_cycles", cnt, n + 3);
		chk("wake_rst", {31'h0, sys_rst}, 32'h1);
		@(posedge clk);
		irq_src <= 8'h00;
		rd_chk("cause_sleep", `PMRC_OFS_CAUSE, {28'h0, `PMRC_CAUSE_SLEEP});
		chk("irq_wake", {31'h0, irq}, 32'h1);
		rd_chk("stat_wake", `PMRC_OFS_INT_STAT, 32'h2);
		wr_reg(`PMRC_OFS_INT_STAT, 32'h2);
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		cyc(1);
		chk("mode_rst", {29'h0, mode}, 32'h1);
		rd_chk("cause_rst", `PMRC_OFS_CAUSE, {28'h0, `PMRC_CAUSE_HARD});
		cyc(20);
		chk("sys_rst_end", {31'h0, sys_rst}, 32'h0);
		rd_chk("unmapped", 8'h3C, 32'h0);
		@(posedge clk);
		busy <= 8'h5A;
		wr_reg(`PMRC_OFS_UNIT_EN, 32'h0F);
		cyc(1);
		chk("gate_norm", {23'h0, cpu_en, periph_en}, 32'h10A);
		wr_reg(`PMRC_OFS_IRQ_EN, 32'h02);
		wr_reg(`PMRC_OFS_INT_MASK, 32'h03);
		wr_reg(`PMRC_OFS_CTRL, 32'h1);
		cyc(1);
		chk("mode_idle", {29'h0, mode}, 32'h2);
		chk("gate_idle", {23'h0, cpu_en, periph_en}, 32'h00A);
		@(posedge clk);
		irq_src <= 8'h01;
		cyc(4);
		chk("idle_hold", {29'h0, mode}, 32'h2);
		@(posedge clk);
		irq_src <= 8'h03;
		cyc(2);
		chk("idle_exit", {29'h0, mode}, 32'h1);
		chk("irq_idle", {31'h0, irq}, 32'h1);
		@(posedge clk);
		irq_src <= 8'h00;
		rd_chk("stat_idle", `PMRC_OFS_INT_STAT, 32'h1);
		wr_reg(`PMRC_OFS_INT_MASK, 32'h0);
		cyc(1);
		chk("irq_masked", {31'h0, irq}, 32'h0);
		wr_reg(`PMRC_OFS_INT_MASK, 32'h3);
		wr_reg(`PMRC_OFS_INT_STAT, 32'h1);
		cyc(1);
		chk("irq_clear", {31'h0, irq}, 32'h0);
		wr_reg(`PMRC_OFS_WAKE_EN, 32'h04);
		sleep_wake(1'b1, FAST);
		sleep_wake(1'b0, SLOW);
		@(posedge clk);
		wdog <= 1'b1;
		@(posedge clk);
		wdog <= 1'b0;
		cyc(2);
		chk("wdog_rst", {31'h0, sys_rst}, 32'h1);
		rd_chk("cause_wdog", `PMRC_OFS_CAUSE, {28'h0, `PMRC_CAUSE_WDOG});
		wr_reg(`PMRC_OFS_CTRL, 32'h8);
		cyc(2);
		rd_chk("cause_soft", `PMRC_OFS_CAUSE, {28'h0, `PMRC_CAUSE_SOFT});
		@(posedge clk);
		hard_n <= 1'b0;
		cyc(3);
		@(posedge clk);
		hard_n <= 1'b1;
		cyc(6);
		rd_chk("cause_hard", `PMRC_OFS_CAUSE, {28'h0, `PMRC_CAUSE_HARD});
		wr_reg(`PMRC_OFS_RTC_TRIM, 32'h80);
		rd_chk("rtc_trim", `PMRC_OFS_RTC_TRIM, 32'h80);
		ticks = 0;
		// trimmed to 32896 Hz, 31000 cycles hold about 10.2 periods: 10 or 11 ticks
		repeat (31000) begin
			cyc(1);
			if (tick === 1'b1) ticks++;
		end
		chk("rtc_ticks", {31'h0, ticks inside {[10:11]}}, 32'h1);
		conclude();
	end

	// ---------------------------------------------------------------
	// watchdog against a hang
	// ---------------------------------------------------------------
	initial begin
		repeat (60000) @(posedge clk);
		n_mismatch++;
		conclude();
	end
endmodule
